// *** rpdw_consts.svh ***
// constants for the radio packet descriptor walker
`ifndef RPDW_CONSTS_SVH
`define RPDW_CONSTS_SVH
// descriptor word byte offsets, also the shadow register addresses
`define RPDW_OFF_NEXT 8'h00
`define RPDW_OFF_CTRL 8'h04
`define RPDW_OFF_PAYLOAD 8'h08
`define RPDW_OFF_TIMER 8'h0c
`define RPDW_OFF_SPARE 8'h10
// walker registers
`define RPDW_OFF_RUN 8'h20
`define RPDW_OFF_HEAD 8'h24
`define RPDW_OFF_STATUS 8'h28
`define RPDW_OFF_SEED 8'h2c
`define RPDW_OFF_REGION 8'h30
`define RPDW_OFF_CAPTURE 8'h34
`define RPDW_OFF_GLOBAL 8'h38
`define RPDW_WORD_RESET 32'h0000_0000
// control word fields
`define RPDW_B_CAL 0
`define RPDW_B_ALG2 1
`define RPDW_B_KEEP 2
`define RPDW_B_SEED 4
`define RPDW_B_ADV 5
`define RPDW_B_SN 6
`define RPDW_B_INC 7
`define RPDW_B_NEXTDIR 8
`define RPDW_B_TREADY 9
`define RPDW_B_PREADY 10
`define RPDW_B_WOFF 12
// timer word fields
`define RPDW_T2_MSB 19
`define RPDW_B_T2EN 20
`define RPDW_B_CSYNC 22
`define RPDW_B_CLAST 23
`define RPDW_B_ACKIRQ 24
// status fields
`define RPDW_S_ADDRERR 0
`define RPDW_S_ADDRIRQ 1
`define RPDW_S_CSYNC 2
`define RPDW_S_CLAST 3
`define RPDW_S_BUSY 4
`define RPDW_S_W1C_MASK 32'h0000_000f
// fixed crc seed
`define RPDW_CRC_FIXED 24'h555555
// timing
`define RPDW_CLK_PERIOD_NS 40
`define RPDW_US_NS 1000
`define RPDW_US_CYCLES (`RPDW_US_NS / `RPDW_CLK_PERIOD_NS)
`endif

// *** rpdw_pkg.sv ***
// types of the radio packet descriptor walker
`default_nettype none
package rpdw_pkg;
	// sequencer phases
	typedef enum logic [2:0] {
		RPDW_IDLE, RPDW_FETCH, RPDW_INIT2, RPDW_DINIT,
		RPDW_XFER, RPDW_WBACK, RPDW_NEXT
	} rpdw_state_t;
	// per-packet settings handed to the radio datapath
	typedef struct packed {
		logic full_cal;
		logic hop_alg2;
		logic chan_inc;
		logic advertising;
		logic auto_seqnum;
		logic always_advance;
		logic whitening_off;
		logic transmit;
		logic [23:0] crc_seed;
	} rpdw_radio_cfg_t;
endpackage
`default_nettype wire

// *** rpdw_desc_mem.sv ***
// five-word shadow of the current packet descriptor
`timescale 1ns/1ns
`default_nettype none
`include "rpdw_consts.svh"
module rpdw_desc_mem #(
	parameter int WORDS = 5
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// write port
	input wire logic we,
	input wire logic [2:0] waddr,
	input wire logic [31:0] wdata,
	// registered read port
	input wire logic [2:0] raddr,
	output logic [31:0] rdata
);
	logic [31:0] mem [WORDS]; // descriptor words
	generate
		if (WORDS < 1 || WORDS > 8) begin : g_chk
			$error("rpdw_desc_mem: WORDS out of range");
		end
	endgenerate
	// storage, reset so readback is defined
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < WORDS; i++) begin
				mem[i] <= `RPDW_WORD_RESET;
			end
		end else if (we && (int'(waddr) < WORDS)) begin
			mem[waddr] <= wdata;
		end
	end
	// read data always from a flop
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= `RPDW_WORD_RESET;
		end else if (int'(raddr) < WORDS) begin
			rdata <= mem[raddr];
		end else begin
			rdata <= `RPDW_WORD_RESET;
		end
	end
endmodule
`default_nettype wire

// *** rpdw_walker.sv ***
// radio packet descriptor walker: apb registers and linked-list sequencer
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "rpdw_consts.svh"
module rpdw_walker
	import rpdw_pkg::*;
#(
	parameter int DESC_WORDS = 5
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// system ram read master
	output logic mem_req,
	output logic [31:0] mem_addr,
	input wire logic mem_ack,
	input wire logic [31:0] mem_rdata,
	// radio datapath
	output rpdw_radio_cfg_t radio_cfg,
	output logic [31:0] payload_buffer_address,
	output logic peer_ack_irq_enable,
	output logic xfer_start,
	input wire logic xfer_done,
	output logic keep_radio_token,
	output logic secondary_timer_trigger,
	// time capture sources
	input wire logic [31:0] interpolated_time,
	input wire logic sync_detect,
	input wire logic last_bit_done
);
	rpdw_state_t state; // sequencer phase
	logic run; // software enable of the walk
	logic [31:0] head; // first descriptor address
	logic [23:0] crc_seed_value; // programmed crc seed
	logic [7:0] ram_region; // top address byte of ram
	logic address_error_irq_enable; // global enable
	logic [31:0] time_capture_value; // captured time
	logic address_pointer_error; // sticky status
	logic addr_irq_flag; // sticky interrupt flag
	logic capture_sync_flag; // sticky capture flag
	logic capture_last_flag; // sticky capture flag
	logic [31:0] base; // current descriptor address
	logic [31:0] next_ptr; // fetched next pointer
	logic [31:0] ctrl; // fetched control word
	logic [31:0] tword; // fetched timer word
	logic [2:0] widx; // word being fetched
	logic current_direction; // 1 transmit
	logic [19:0] t2_left; // microseconds to trigger
	logic t2_armed; // secondary timer running
	logic [4:0] us_cnt; // microsecond divider
	logic us_tick; // one pulse each microsecond
	logic [31:0] mem_word; // shadow readback
	logic set_err; // address error event
	logic wr; // apb write strobe
	logic rd_map; // apb address is mapped
	localparam logic [4:0] US_LAST = 5'(`RPDW_US_CYCLES - 1);
	generate
		if (DESC_WORDS != 5 || `RPDW_US_CYCLES < 1 || `RPDW_US_CYCLES > 32) begin : g_chk
			$error("rpdw_walker: unsupported configuration");
		end
	endgenerate
	// word-aligned check, used for head and next pointers
	function automatic logic misaligned(input logic [31:0] a);
		misaligned = (a[1:0] != 2'b00);
	endfunction
	// address of descriptor word n
	function automatic logic [31:0] word_addr(input logic [31:0] b, input logic [2:0] n);
		word_addr = b + {27'h0, n, 2'b00};
	endfunction
	// apb decode; zero wait states since shadow data is registered from setup
	assign wr = psel && penable && pwrite;
	assign rd_map = (paddr[1:0] == 2'b00) && (paddr <= `RPDW_OFF_SPARE
		|| (paddr >= `RPDW_OFF_RUN && paddr <= `RPDW_OFF_GLOBAL));
	assign pready = 1'b1;
	assign pslverr = psel && penable && !rd_map;
	// read mux
	always_comb begin
		case (paddr)
			`RPDW_OFF_NEXT, `RPDW_OFF_CTRL, `RPDW_OFF_PAYLOAD,
			`RPDW_OFF_TIMER, `RPDW_OFF_SPARE: prdata = mem_word;
			`RPDW_OFF_RUN: prdata = {31'h0, run};
			`RPDW_OFF_HEAD: prdata = head;
			`RPDW_OFF_STATUS: prdata = {27'h0, state != RPDW_IDLE,
				capture_last_flag, capture_sync_flag, addr_irq_flag,
				address_pointer_error};
			`RPDW_OFF_SEED: prdata = {8'h0, crc_seed_value};
			`RPDW_OFF_REGION: prdata = {24'h0, ram_region};
			`RPDW_OFF_CAPTURE: prdata = time_capture_value;
			`RPDW_OFF_GLOBAL: prdata = {31'h0, address_error_irq_enable};
			default: prdata = 32'h0;
		endcase
	end
	// shadow of the descriptor: fetch has priority over software writes
	rpdw_desc_mem #(
		.WORDS(DESC_WORDS)
	) u_mem (
		.clk(pclk),
		.rst_n(presetn),
		.we((state == RPDW_FETCH && mem_ack) || (wr && paddr < `RPDW_OFF_RUN)),
		.waddr((state == RPDW_FETCH && mem_ack) ? widx : paddr[4:2]),
		.wdata((state == RPDW_FETCH && mem_ack) ? mem_rdata : pwdata),
		.raddr(paddr[4:2]),
		.rdata(mem_word)
	);
	// software configuration registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run <= 1'b0;
			head <= `RPDW_WORD_RESET;
			crc_seed_value <= 24'h0;
			ram_region <= 8'h0;
			address_error_irq_enable <= 1'b0;
		end else if (wr) begin
			case (paddr)
				`RPDW_OFF_RUN: run <= pwdata[0];
				`RPDW_OFF_HEAD: head <= pwdata;
				`RPDW_OFF_SEED: crc_seed_value <= pwdata[23:0];
				`RPDW_OFF_REGION: ram_region <= pwdata[7:0];
				`RPDW_OFF_GLOBAL: address_error_irq_enable <= pwdata[0];
				default: ;
			endcase
		end
	end
	// address error event from head, next or payload pointer checks
	// the region check looks at the word just read, not the stale control copy
	assign set_err = (state == RPDW_IDLE && run && misaligned(head))
		|| (state == RPDW_NEXT && misaligned(next_ptr))
		|| (state == RPDW_INIT2 && mem_ack && mem_rdata[`RPDW_B_TREADY]
			&& payload_buffer_address[31:24] != ram_region);
	// sticky error flags; a new event beats a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			address_pointer_error <= 1'b0;
			addr_irq_flag <= 1'b0;
		end else begin
			if (set_err) begin
				address_pointer_error <= 1'b1;
			end else if (wr && paddr == `RPDW_OFF_STATUS && pwdata[`RPDW_S_ADDRERR]) begin
				address_pointer_error <= 1'b0;
			end
			if (set_err && address_error_irq_enable) begin
				addr_irq_flag <= 1'b1;
			end else if (wr && paddr == `RPDW_OFF_STATUS && pwdata[`RPDW_S_ADDRIRQ]) begin
				addr_irq_flag <= 1'b0;
			end
		end
	end
	// time capture: the most recent enabled event stays in the register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			time_capture_value <= `RPDW_WORD_RESET;
			capture_sync_flag <= 1'b0;
			capture_last_flag <= 1'b0;
		end else begin
			if (state == RPDW_XFER && ((sync_detect && tword[`RPDW_B_CSYNC])
				|| (last_bit_done && tword[`RPDW_B_CLAST]))) begin
				time_capture_value <= interpolated_time;
			end
			if (state == RPDW_XFER && sync_detect && tword[`RPDW_B_CSYNC]) begin
				capture_sync_flag <= 1'b1;
			end else if (wr && paddr == `RPDW_OFF_STATUS && pwdata[`RPDW_S_CSYNC]) begin
				capture_sync_flag <= 1'b0;
			end
			if (state == RPDW_XFER && last_bit_done && tword[`RPDW_B_CLAST]) begin
				capture_last_flag <= 1'b1;
			end else if (wr && paddr == `RPDW_OFF_STATUS && pwdata[`RPDW_S_CLAST]) begin
				capture_last_flag <= 1'b0;
			end
		end
	end
	// sequencer walking the linked list
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= RPDW_IDLE;
			base <= `RPDW_WORD_RESET;
			widx <= 3'd0;
			next_ptr <= `RPDW_WORD_RESET;
			ctrl <= `RPDW_WORD_RESET;
			tword <= `RPDW_WORD_RESET;
			payload_buffer_address <= `RPDW_WORD_RESET;
			current_direction <= 1'b0;
		end else begin
			case (state)
				RPDW_IDLE: begin
					if (run && !misaligned(head)) begin
						base <= head;
						widx <= 3'd0;
						state <= RPDW_FETCH;
					end
				end
				RPDW_FETCH: begin
					if (mem_ack) begin
						case (widx)
							3'd0: next_ptr <= mem_rdata;
							3'd1: ctrl <= mem_rdata;
							3'd2: payload_buffer_address <= mem_rdata;
							3'd3: tword <= mem_rdata;
							default: ;
						endcase
						widx <= widx + 3'd1;
						if (widx == 3'(DESC_WORDS - 1)) begin
							state <= RPDW_INIT2;
						end
					end
				end
				RPDW_INIT2: begin
					// control word re-read until the table is marked ready
					if (mem_ack) begin
						ctrl <= mem_rdata;
						if (mem_rdata[`RPDW_B_TREADY]) begin
							state <= RPDW_DINIT;
						end
					end
				end
				RPDW_DINIT: begin
					// only a transmission waits for its payload
					if (!current_direction) begin
						state <= RPDW_XFER;
					end else if (mem_ack && mem_rdata[`RPDW_B_PREADY]) begin
						ctrl <= mem_rdata;
						state <= RPDW_XFER;
					end
				end
				RPDW_XFER: begin
					if (xfer_done) begin
						state <= RPDW_WBACK;
					end
				end
				RPDW_WBACK: begin
					current_direction <= ctrl[`RPDW_B_NEXTDIR];
					state <= RPDW_NEXT;
				end
				RPDW_NEXT: begin
					if (!run || misaligned(next_ptr)) begin
						state <= RPDW_IDLE;
					end else begin
						base <= next_ptr;
						widx <= 3'd0;
						state <= RPDW_FETCH;
					end
				end
				default: state <= RPDW_IDLE;
			endcase
		end
	end
	// ram read request held until acknowledged
	always_comb begin
		mem_req = 1'b0;
		mem_addr = base;
		case (state)
			RPDW_FETCH: begin
				mem_req = 1'b1;
				mem_addr = word_addr(base, widx);
			end
			RPDW_INIT2: begin
				mem_req = 1'b1;
				mem_addr = word_addr(base, 3'd1);
			end
			RPDW_DINIT: begin
				mem_req = current_direction;
				mem_addr = word_addr(base, 3'd1);
			end
			default: ;
		endcase
	end
	// transfer start pulse on entering the transfer phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			xfer_start <= 1'b0;
		end else begin
			xfer_start <= (state == RPDW_DINIT)
				&& (!current_direction || (mem_ack && mem_rdata[`RPDW_B_PREADY]));
		end
	end
	// radio settings decoded from the control word, peer ack enable from the timer word
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			radio_cfg <= '0;
			peer_ack_irq_enable <= 1'b0;
		end else begin
			radio_cfg.full_cal <= ctrl[`RPDW_B_CAL];
			radio_cfg.hop_alg2 <= ctrl[`RPDW_B_INC] && ctrl[`RPDW_B_ALG2];
			radio_cfg.chan_inc <= ctrl[`RPDW_B_INC];
			radio_cfg.advertising <= ctrl[`RPDW_B_ADV];
			radio_cfg.auto_seqnum <= ctrl[`RPDW_B_SN];
			radio_cfg.always_advance <= !ctrl[`RPDW_B_SN];
			radio_cfg.whitening_off <= ctrl[`RPDW_B_WOFF];
			radio_cfg.transmit <= current_direction;
			radio_cfg.crc_seed <= ctrl[`RPDW_B_SEED] ? crc_seed_value
				: `RPDW_CRC_FIXED;
			peer_ack_irq_enable <= tword[`RPDW_B_ACKIRQ];
		end
	end
	// radio token: held past the transfer only when asked
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			keep_radio_token <= 1'b0;
		end else if (state == RPDW_XFER) begin
			keep_radio_token <= 1'b1;
		end else if (state == RPDW_WBACK) begin
			keep_radio_token <= ctrl[`RPDW_B_KEEP];
		end else if (state == RPDW_IDLE) begin
			keep_radio_token <= 1'b0;
		end
	end
	// microsecond enable divider
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			us_cnt <= 5'd0;
			us_tick <= 1'b0;
		end else begin
			us_tick <= (us_cnt == US_LAST);
			us_cnt <= (us_cnt == US_LAST) ? 5'd0 : us_cnt + 5'd1;
		end
	end
	// secondary timer counts from the end of the sequence, first tick may be short
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			t2_armed <= 1'b0;
			t2_left <= 20'h0;
			secondary_timer_trigger <= 1'b0;
		end else begin
			secondary_timer_trigger <= 1'b0;
			if (state == RPDW_WBACK && tword[`RPDW_B_T2EN]) begin
				t2_armed <= 1'b1;
				t2_left <= tword[`RPDW_T2_MSB:0];
			end else if (t2_armed && us_tick) begin
				if (t2_left == 20'h0) begin
					t2_armed <= 1'b0;
					secondary_timer_trigger <= 1'b1;
				end else begin
					t2_left <= t2_left - 20'h1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// *** rpdw_walker_unused_guard.sv ***
// empty file, holds no module
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// *** rpdw_walker_monitor.sv ***
// assertion checker on the descriptor walker ports
`timescale 1ns/1ns
`default_nettype none
module rpdw_walker_monitor
	import rpdw_pkg::*;
#(
	parameter int DESC_WORDS = 5
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb side
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// ram side
	input wire logic mem_req,
	input wire logic [31:0] mem_addr,
	input wire logic mem_ack,
	// radio side
	input wire rpdw_radio_cfg_t radio_cfg,
	input wire logic [31:0] payload_buffer_address,
	input wire logic xfer_start,
	input wire logic keep_radio_token,
	input wire logic secondary_timer_trigger
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// request still open
	sequence s_waiting;
		mem_req && !mem_ack;
	endsequence
	// request held unchanged
	sequence s_still;
		mem_req && $stable(mem_addr);
	endsequence
	AST_MEMHOLD: assert property (s_waiting |=> s_still)
		else $error("ram request dropped or moved before ack");
	AST_FETCH_ALIGN: assert property ($rose(mem_req) |-> mem_addr[1:0] == 2'b00)
		else $error("fetch from misaligned descriptor");
	AST_START_PULSE: assert property (xfer_start |=> !xfer_start)
		else $error("transfer start longer than one cycle");
	AST_TOKEN_XFER: assert property (xfer_start |=> keep_radio_token)
		else $error("radio token not held in transfer");
	AST_ADVANCE: assert property (xfer_start |-> radio_cfg.always_advance != radio_cfg.auto_seqnum)
		else $error("pointer advance not inverse of seqnum");
	AST_CFG_STABLE: assert property (xfer_start |=> $stable(radio_cfg) && $stable(payload_buffer_address))
		else $error("settings moved at transfer start");
	AST_TRIG_PULSE: assert property (secondary_timer_trigger |=> !secondary_timer_trigger)
		else $error("timer trigger longer than one cycle");
	AST_SLVERR: assert property (psel && penable && !pwrite && paddr == 8'h14 |-> pslverr && prdata == 32'h0)
		else $error("unmapped read not refused");
	AST_NOWAIT: assert property (psel && !penable |=> pready)
		else $error("apb access phase stalled");
endmodule
bind rpdw_walker rpdw_walker_monitor #(.DESC_WORDS(DESC_WORDS)) i_rpdw_walker_monitor (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .radio_cfg(radio_cfg),
	.payload_buffer_address(payload_buffer_address), .xfer_start(xfer_start),
	.keep_radio_token(keep_radio_token), .secondary_timer_trigger(secondary_timer_trigger)
);
`default_nettype wire

// *** rpdw_ram_model.sv ***
// system ram model holding the firmware descriptor tables
`timescale 1ns/1ns
`default_nettype none
module rpdw_ram_model (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// read port from the walker
	input wire logic mem_req,
	input wire logic [31:0] mem_addr,
	output logic mem_ack,
	output logic [31:0] mem_rdata,
	// latency select
	input wire logic slow
);
	logic [31:0] mem [0:255]; // tables, written by firmware
	logic [1:0] wait_cnt; // cycles spent on this request
	// one word per request; data toggles off ack so stale words never pass
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_ack <= 1'b0;
			mem_rdata <= 32'h0;
			wait_cnt <= 2'd0;
		end else if (mem_req && !mem_ack && wait_cnt >= (slow ? 2'd3 : 2'd0)) begin
			mem_ack <= 1'b1;
			mem_rdata <= mem[mem_addr[9:2]];
			wait_cnt <= 2'd0;
		end else begin
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
			if (mem_req && !mem_ack) begin
				wait_cnt <= wait_cnt + 2'd1;
			end
		end
	end
endmodule
`default_nettype wire

// *** rpdw_walker_tb_top.sv ***
// self-checking bench for the descriptor walker
`timescale 1ns/1ns
`default_nettype none
`include "rpdw_consts.svh"
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin n_fail++; $display("[ERR] %s exp %0h got %0h", nm, e, a); end end
module rpdw_walker_tb_top import rpdw_pkg::*;;
	typedef struct packed {
		rpdw_radio_cfg_t cfg;
		logic [31:0] pay;
		logic ack;
	} rpdw_exp_t;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h0;
	logic [31:0] pwdata = 32'h0, itime = 32'h0;
	logic xfer_done = 1'b0, sync_detect = 1'b0, last_bit_done = 1'b0, slow = 1'b0;
	logic [31:0] prdata, mem_addr, mem_rdata, pay_out;
	logic pready, pslverr, mem_req, mem_ack, ack_en, xfer_start, keep_tok, trig;
	rpdw_radio_cfg_t radio_cfg;
	rpdw_exp_t xq[$]; // transfers expected to start
	logic [63:0] rq[$]; // reads expected, mask and value
	rpdw_exp_t ev;
	logic [63:0] rv;
	int n_fail = 0, n_checks = 0, k;
	logic [31:0] seed = 32'h9c9acfbd, seedv, ca, cb, ta, pa, pb, tcap;
	always #20 pclk = ~pclk;
	rpdw_walker i_rpdw_walker (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
		.mem_rdata(mem_rdata), .radio_cfg(radio_cfg), .payload_buffer_address(pay_out),
		.peer_ack_irq_enable(ack_en), .xfer_start(xfer_start), .xfer_done(xfer_done),
		.keep_radio_token(keep_tok), .secondary_timer_trigger(trig), .interpolated_time(itime),
		.sync_detect(sync_detect), .last_bit_done(last_bit_done));
	rpdw_ram_model i_rpdw_ram_model (.pclk(pclk), .presetn(presetn), .mem_req(mem_req),
		.mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .slow(slow));
	// xorshift source
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// settings a descriptor should hand to the datapath
	function automatic rpdw_exp_t note(input logic [31:0] c, t, p, input logic tx);
		rpdw_exp_t e;
		e.cfg = {c[0], c[1] & c[7], c[7], c[5], c[6], ~c[6], c[12], tx,
			c[4] ? seedv[23:0] : `RPDW_CRC_FIXED};
		e.pay = p;
		e.ack = t[24];
		return e;
	endfunction
	task automatic give_verdict();
		if (n_fail == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// one apb transfer, released only after pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (i == 50) begin
			n_fail++;
			give_verdict();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		rq.push_back({m, e});
		apb(1'b0, a, 32'h0);
	endtask
	// bounded wait for a start (0) or a timer trigger (1)
	task automatic wait_on(input int s, output int n);
		for (n = 1; n < 3000; n++) begin
			@(posedge pclk);
			if ((s == 0 ? xfer_start : trig) === 1'b1) return;
		end
		n_fail++;
		give_verdict();
	endtask
	task automatic pulse_done();
		xfer_done <= 1'b1;
		@(posedge pclk);
		xfer_done <= 1'b0;
	endtask
	// compare each observed result with the oldest note
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite && rq.size() > 0) begin
			rv = rq.pop_front();
			`CHK("prdata", rv[31:0], prdata & rv[63:32])
		end
		if (xfer_start === 1'b1) begin
			if (xq.size() == 0) begin
				`CHK("xfer_start", 1'b0, xfer_start)
			end else begin
				ev = xq.pop_front();
				`CHK("radio_cfg", ev.cfg, radio_cfg)
				`CHK("payload", ev.pay, pay_out)
				`CHK("peer_ack", ev.ack, ack_en)
			end
		end
	end
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (k = 0; k < 5; k++) rd(8'(4 * k), `RPDW_WORD_RESET, 32'hffffffff);
		rd(8'h14, 32'h0, 32'hffffffff);
		tcap = xs();
		apb(1'b1, `RPDW_OFF_TIMER, tcap);
		rd(`RPDW_OFF_TIMER, tcap, 32'hffffffff);
		// firmware builds packet a (receive) then b (transmit)
		seedv = xs();
		ca = (xs() & 32'h10f7) | 32'h101;
		cb = (xs() & 32'h10f7) | 32'h200;
		ta = (xs() & 32'h0100_0000) | 32'h0040_0000;
		pa = xs();
		pa[31:24] = ~seedv[31:24];
		pb = xs();
		pb[31:24] = seedv[31:24];
		i_rpdw_ram_model.mem[8'h40] = 32'h140;
		i_rpdw_ram_model.mem[8'h41] = ca;
		i_rpdw_ram_model.mem[8'h42] = pa;
		i_rpdw_ram_model.mem[8'h43] = ta;
		i_rpdw_ram_model.mem[8'h50] = 32'h142;
		i_rpdw_ram_model.mem[8'h51] = cb;
		i_rpdw_ram_model.mem[8'h52] = pb;
		i_rpdw_ram_model.mem[8'h53] = 32'h0010_0002;
		apb(1'b1, `RPDW_OFF_SEED, seedv);
		apb(1'b1, `RPDW_OFF_REGION, {24'h0, seedv[31:24]});
		apb(1'b1, `RPDW_OFF_GLOBAL, 32'h1);
		apb(1'b1, `RPDW_OFF_HEAD, 32'h100);
		apb(1'b1, `RPDW_OFF_RUN, 32'h1);
		repeat (40) @(posedge pclk);
		i_rpdw_ram_model.mem[8'h41] = ca | 32'h200;
		xq.push_back(note(ca, ta, pa, 1'b0));
		wait_on(0, k);
		tcap = xs();
		itime <= tcap;
		sync_detect <= 1'b1;
		@(posedge pclk);
		sync_detect <= 1'b0;
		itime <= ~tcap;
		slow <= 1'b1;
		rd(`RPDW_OFF_STATUS, 32'h7, 32'hf);
		apb(1'b1, `RPDW_OFF_STATUS, 32'h3);
		pulse_done();
		repeat (2) @(posedge pclk);
		`CHK("token", ca[2], keep_tok)
		repeat (38) @(posedge pclk);
		i_rpdw_ram_model.mem[8'h51] = cb | 32'h400;
		i_rpdw_ram_model.mem[8'h41] = ca; // keeps the relaunched head blocked
		i_rpdw_ram_model.mem[8'h40] = 32'h100;
		xq.push_back(note(cb, 32'h0, pb, 1'b1));
		wait_on(0, k);
		last_bit_done <= 1'b1;
		@(posedge pclk);
		last_bit_done <= 1'b0;
		pulse_done();
		wait_on(1, k);
		`CHK("timer_delay", 1'b1, k >= 50 && k <= 80)
		rd(`RPDW_OFF_STATUS, 32'h7, 32'hf);
		rd(`RPDW_OFF_CAPTURE, tcap, 32'hffffffff);
		apb(1'b1, `RPDW_OFF_STATUS, 32'hf);
		rd(`RPDW_OFF_STATUS, 32'h0, 32'hf);
		`CHK("token_idle", 1'b0, keep_tok)
		give_verdict();
	end
endmodule
`default_nettype wire
